// File: logic/tap_pkg.sv
/*
 * Shared constants, state codes and carrier structs of the memory test port.
 * Assumes a test clock from the external tester and a core clock inside the memory.
 */
package tap_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register sizes
  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int BSR_MAX = 70;
  localparam int BSR_LEN_X36 = 70;
  localparam int BSR_LEN_X18 = 51;
  localparam int TLR_TMS_ONES = 5;  // tms-high edges that always reach reset

  ////////////////////////////////////////////////////////////////////////////
  // customary instruction codes, overridable at the top
  localparam logic [2:0] OP_EXTEST = 3'h0;
  localparam logic [2:0] OP_IDCODE = 3'h1;
  localparam logic [2:0] OP_SAMPLE_Z = 3'h2;
  localparam logic [2:0] OP_SAMPLE = 3'h4;
  localparam logic [2:0] OP_BYPASS = 3'h7;
  localparam logic [1:0] IR_CAPTURE_LOW = 2'h1;  // fixed 01 pattern
  localparam logic IR_CAPTURE_TOP = 1'h0;

  ////////////////////////////////////////////////////////////////////////////
  // identification word layout
  localparam int ID_REV_LSB = 28;
  localparam int ID_DEPTH_LSB = 23;
  localparam int ID_WIDTH_LSB = 18;
  localparam logic [4:0] ID_DEPTH_X36 = 5'h07;
  localparam logic [4:0] ID_DEPTH_X18 = 5'h08;
  localparam logic [4:0] ID_WIDTH_X36 = 5'h04;
  localparam logic [4:0] ID_WIDTH_X18 = 5'h03;
  localparam logic [3:0] ID_REV_DEFAULT = 4'h0;         // arbitrary value
  localparam logic [16:0] ID_MAKER_DEFAULT = 17'h00a5a; // arbitrary value
  localparam logic ID_MARKER = 1'h1;                    // bit 0 always one

  ////////////////////////////////////////////////////////////////////////////
  // controller states, one-hot
  typedef enum logic [15:0] {
    ST_RESET      = 16'h0001,
    ST_IDLE       = 16'h0002,
    ST_SEL_DR     = 16'h0004,
    ST_CAP_DR     = 16'h0008,
    ST_SHIFT_DR   = 16'h0010,
    ST_EXIT1_DR   = 16'h0020,
    ST_PAUSE_DR   = 16'h0040,
    ST_EXIT2_DR   = 16'h0080,
    ST_UPDATE_DR  = 16'h0100,
    ST_SEL_IR     = 16'h0200,
    ST_CAP_IR     = 16'h0400,
    ST_SHIFT_IR   = 16'h0800,
    ST_EXIT1_IR   = 16'h1000,
    ST_PAUSE_IR   = 16'h2000,
    ST_EXIT2_IR   = 16'h4000,
    ST_UPDATE_IR  = 16'h8000
  } tap_state_t;

  // data path chosen by the current instruction
  typedef enum logic [2:0] {
    PATH_BSR = 3'h1,
    PATH_ID  = 3'h2,
    PATH_BYP = 3'h4
  } path_t;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    tap_state_t st;
    logic [IR_W-1:0] ir;
    logic [IR_W-1:0] ir_shift;
    logic [BSR_MAX-1:0] bsr;
    logic [ID_W-1:0] id_shift;
    logic byp;
  } tap_q_t;

  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } tdo_q_t;

  typedef struct packed {
    logic mem_out_hiz;
  } core_q_t;

endpackage : tap_pkg

// File: logic/sync2.sv
/*
 * Two-flop synchroniser of parameter width.
 * Assumes each bit is an independent level; no word coherence is given.
 */
`timescale 1ns/1ns
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : sync2

// File: logic/sram_boundary_scan_tap.sv
/*
 * Reduced boundary-scan test port of a burst memory: controller, instruction,
 * bypass, identification and boundary registers, serial output stage.
 * Assumes tck from the tester, the memory pin ring on the core clock, and pad
 * pull-ups reported through the *_drive inputs.
 */
// How it works
// RULE1: inputs sampled on tck rise; serial output updated on tck fall.
// RULE2: undriven mode-select reads as one, so the port drifts to reset.
// RULE3: serial in enters the MSB; serial out leaves from the LSB.
// RULE4: serial output enabled only in the two shift states.
// RULE5: five mode-select-high edges always land in the reset state.
// RULE6: test port reset never touches the memory's normal operation.
// RULE7: power-up reset clears the port and floats the serial output.
// RULE8: three-bit instruction register shifted in the instruction-shift state.
// RULE9: reset and power-up preset the instruction to identification read.
// RULE10: instruction capture loads 01 into the two low bits.
// RULE11: bypass is one flip-flop, cleared when bypass runs.
// RULE12: boundary register is 70 bits wide-config, 51 bits narrow-config.
// RULE13: boundary register captures the pin ring, then shifts serially.
// RULE14: all-zero, sample and sample-z instructions select the boundary register.
// RULE15: identification instruction captures a fixed 32-bit code and shifts it.
// RULE16: identification code is hardwired with maker and device fields.
// RULE17: the tester must not load the three reserved codes.
// RULE18: port never drives the memory core or preloads output buffers.
// RULE19: exactly one data register sits on the serial path at once.
// RULE20: all-zero instruction acts as sample but floats memory outputs.
// RULE21: sample-z selects the boundary register and floats memory outputs.
// RULE22: with bypass loaded, the bypass bit is the shift path.
// RULE23: data update under sample changes nothing, like a pause.
// RULE24: standard sixteen-state controller advanced by mode-select on tck rise.
// RULE25: instruction codes are parameters with customary defaults.
`timescale 1ns/1ns
module sram_boundary_scan_tap
  import tap_pkg::*;
#(
  parameter bit WIDE_X36 = 1'b1,
  // RULE25 codes as parameters
  parameter logic [2:0] CODE_EXTEST = tap_pkg::OP_EXTEST,
  parameter logic [2:0] CODE_IDCODE = tap_pkg::OP_IDCODE,
  parameter logic [2:0] CODE_SAMPLE_Z = tap_pkg::OP_SAMPLE_Z,
  parameter logic [2:0] CODE_SAMPLE = tap_pkg::OP_SAMPLE,
  parameter logic [2:0] CODE_BYPASS = tap_pkg::OP_BYPASS,
  parameter logic [3:0] ID_REVISION = tap_pkg::ID_REV_DEFAULT,    // arbitrary value
  parameter logic [16:0] ID_MAKER = tap_pkg::ID_MAKER_DEFAULT     // arbitrary value
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic tck,
  input wire logic tms_in,
  input wire logic tms_drive,
  input wire logic tdi_in,
  input wire logic tdi_drive,
  input wire logic [tap_pkg::BSR_MAX-1:0] io_ring,
  output logic tdo,
  output logic tdo_oe,
  output logic mem_out_hiz
);

  import tap_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // configuration constants
  localparam int BSR_LEN = WIDE_X36 ? BSR_LEN_X36 : BSR_LEN_X18;
  localparam logic [4:0] ID_DEPTH = WIDE_X36 ? ID_DEPTH_X36 : ID_DEPTH_X18;
  localparam logic [4:0] ID_WIDTH = WIDE_X36 ? ID_WIDTH_X36 : ID_WIDTH_X18;

  // RULE16 fixed identification word
  // revision, depth, width, maker in bits 17:1, marker one in bit 0
  localparam logic [ID_W-1:0] ID_WORD = {ID_REVISION, ID_DEPTH, ID_WIDTH, ID_MAKER, ID_MARKER};

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // RULE24 standard controller transitions
  function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
    tap_state_t n;
    n = ST_RESET;
    unique case (s)
      ST_RESET:     n = m ? ST_RESET : ST_IDLE;
      ST_IDLE:      n = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR:    n = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR:    n = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR:  n = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR:  n = m ? ST_UPDATE_DR : ST_PAUSE_DR;
      ST_PAUSE_DR:  n = m ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR:  n = m ? ST_UPDATE_DR : ST_SHIFT_DR;
      ST_UPDATE_DR: n = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR:    n = m ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR:    n = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR:  n = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR:  n = m ? ST_UPDATE_IR : ST_PAUSE_IR;
      ST_PAUSE_IR:  n = m ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR:  n = m ? ST_UPDATE_IR : ST_SHIFT_IR;
      ST_UPDATE_IR: n = m ? ST_SEL_DR : ST_IDLE;
      default:      n = ST_RESET;  // corrupted code falls back to reset
    endcase
    return n;
  endfunction : tap_next

  // RULE19 one data path per instruction
  function automatic path_t path_of(input logic [2:0] op);
    path_t p;
    // RULE14 boundary register for the three capture instructions
    if (op == CODE_EXTEST || op == CODE_SAMPLE || op == CODE_SAMPLE_Z) begin
      p = PATH_BSR;
    end else if (op == CODE_IDCODE) begin
      p = PATH_ID;
    end else begin
      p = PATH_BYP;  // bypass and reserved codes
    end
    return p;
  endfunction : path_of

  // RULE20 outputs floated by all-zero and sample-z
  function automatic logic hiz_of(input logic [2:0] op);
    return (op == CODE_EXTEST) || (op == CODE_SAMPLE_Z);
  endfunction : hiz_of

  ////////////////////////////////////////////////////////////////////////////
  // pad view and ring crossing

  // RULE2 pull-ups give one on undriven pins
  logic tms_eff;
  logic tdi_eff;
  assign tms_eff = tms_drive ? tms_in : 1'b1;
  assign tdi_eff = tdi_drive ? tdi_in : 1'b1;

  // memory pin ring brought into the test clock domain
  logic [BSR_MAX-1:0] ring_tck;
  sync2 #(.W(BSR_MAX)) ring_sync (
    .clk(tck),
    .rstn(rstn),
    .d(io_ring),
    .q(ring_tck)
  );

  ////////////////////////////////////////////////////////////////////////////
  // controller and registers on tck rise

  tap_q_t q;
  tap_q_t next_q;
  path_t path;

  assign path = path_of(q.ir);

  always_comb begin
    next_q = q;
    // RULE1 all serial inputs taken on the rising edge
    // RULE5 mode-select high walks any state to reset within five edges
    next_q.st = tap_next(q.st, tms_eff);
    unique case (q.st)
      ST_RESET: begin
        // RULE9 reset state presets identification read
        next_q.ir = CODE_IDCODE;
      end
      ST_CAP_IR: begin
        // RULE10 fixed 01 into the low bits
        next_q.ir_shift = {IR_CAPTURE_TOP, IR_CAPTURE_LOW};
      end
      ST_SHIFT_IR: begin
        // RULE8 three-bit serial instruction shift
        // RULE3 in at the MSB, toward the LSB
        next_q.ir_shift = {tdi_eff, q.ir_shift[IR_W-1:1]};
      end
      ST_UPDATE_IR: begin
        next_q.ir = q.ir_shift;
      end
      ST_CAP_DR: begin
        unique case (path)
          PATH_BSR: begin
            // RULE13 pin ring snapshot
            for (int i = 0; i < BSR_MAX; i++) begin
              next_q.bsr[i] = (i < BSR_LEN) ? ring_tck[i] : 1'b0;
            end
          end
          PATH_ID: begin
            // RULE15 load the fixed code
            next_q.id_shift = ID_WORD;
          end
          PATH_BYP: begin
            // RULE11 bypass bit cleared
            next_q.byp = 1'b0;
          end
        endcase
      end
      ST_SHIFT_DR: begin
        unique case (path)
          PATH_BSR: begin
            // RULE12 serial length set by configuration
            for (int i = 0; i < BSR_MAX; i++) begin
              if (i == BSR_LEN - 1) begin
                next_q.bsr[i] = tdi_eff;
              end else if (i < BSR_LEN - 1) begin
                next_q.bsr[i] = q.bsr[i+1];
              end else begin
                next_q.bsr[i] = 1'b0;
              end
            end
          end
          PATH_ID: begin
            next_q.id_shift = {tdi_eff, q.id_shift[ID_W-1:1]};
          end
          PATH_BYP: begin
            // RULE22 single bypass bit on the path
            next_q.byp = tdi_eff;
          end
        endcase
      end
      ST_UPDATE_DR: begin
        // RULE23 no preload, update behaves as a pause
        // RULE18 nothing is ever driven toward the core
        next_q.bsr = q.bsr;
      end
      default: begin
        next_q.ir_shift = q.ir_shift;
      end
    endcase
  end

  // RULE7 power-up reset of the whole port
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      q.st <= ST_RESET;
      q.ir <= CODE_IDCODE;
      q.ir_shift <= '0;
      q.bsr <= '0;
      q.id_shift <= '0;
      q.byp <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial output on tck fall

  tdo_q_t o;
  tdo_q_t next_o;

  always_comb begin
    next_o.tdo = 1'b0;
    // RULE4 drive only in the shift states
    next_o.tdo_oe = (q.st == ST_SHIFT_IR) || (q.st == ST_SHIFT_DR);
    if (q.st == ST_SHIFT_IR) begin
      next_o.tdo = q.ir_shift[0];
    end else if (q.st == ST_SHIFT_DR) begin
      // RULE3 out from the selected LSB
      unique case (path)
        PATH_BSR: next_o.tdo = q.bsr[0];
        PATH_ID:  next_o.tdo = q.id_shift[0];
        PATH_BYP: next_o.tdo = q.byp;
      endcase
    end
  end

  // RULE1 output changes on the falling edge
  always_ff @(negedge tck or negedge rstn) begin
    if (!rstn) begin
      o <= '0;
    end else begin
      o <= next_o;
    end
  end

  assign tdo = o.tdo;
  assign tdo_oe = o.tdo_oe;

  ////////////////////////////////////////////////////////////////////////////
  // output float request into the core domain

  logic hiz_tck;
  logic hiz_core;

  // RULE21 float level held in a tck flop before crossing
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      hiz_tck <= 1'b0;
    end else begin
      hiz_tck <= hiz_of(next_q.ir);
    end
  end

  sync2 #(.W(1)) hiz_sync (
    .clk(core_clk),
    .rstn(rstn),
    .d(hiz_tck),
    .q(hiz_core)
  );

  core_q_t c;
  core_q_t next_c;

  // RULE6 memory sees only this float level
  always_comb begin
    next_c.mem_out_hiz = hiz_core;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      c <= '0;
    end else begin
      c <= next_c;
    end
  end

  assign mem_out_hiz = c.mem_out_hiz;

endmodule : sram_boundary_scan_tap

// File: verif/tap_monitor.sv
/*
 * Checker of the test port: serial timing, reset and capture patterns.
 * Assumes it is bound to the port's top module.
 */
`timescale 1ns/1ns
module tap_monitor (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic tck,
  input wire logic tms_in,
  input wire logic tms_drive,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic mem_out_hiz
);
  logic tms1;
  logic at_rise;
  default clocking cb @(posedge tck); endclocking
  default disable iff (!rstn);
  ////////////////////////
  // undriven mode-select reads high
  assign tms1 = tms_in | !tms_drive;
  // tdo as seen at each rise
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) at_rise <= 1'h0;
    else at_rise <= tdo;
  end
  sequence ones5_s;
    tms1 [*5];
  endsequence
  sequence shift_dr_s;
    ones5_s ##1 !tms1 ##1 tms1 ##1 !tms1 ##1 !tms1;
  endsequence
  sequence shift_ir_s;
    ones5_s ##1 !tms1 ##1 tms1 ##1 tms1 ##1 !tms1 ##1 !tms1;
  endsequence
  ////////////////////////
  tdo_fall_a: assert property (@(negedge tck) tdo == at_rise)
    else $error("tdo moved off falling edge");
  five_ones_a: assert property (ones5_s |=> !tdo_oe)
    else $error("tdo driven after reset walk");
  hiz_release_a: assert property (ones5_s |-> ##2 !mem_out_hiz)
    else $error("outputs floated after reset");
  id_first_a: assert property (shift_dr_s |=> tdo_oe && tdo)
    else $error("id shift not starting with one");
  dr_exit_a: assert property (shift_dr_s ##1 tms1 |=> !tdo_oe)
    else $error("tdo driven after shift");
  ir_capture_a: assert property (shift_ir_s |=> tdo_oe && tdo)
    else $error("ir capture bit0 not one");
  ir_second_a: assert property (shift_ir_s ##1 !tms1 |=> !tdo)
    else $error("ir capture bit1 not zero");
  power_up_a: assert property (@(posedge core_clk)
    $rose(rstn) |-> !tdo_oe && !mem_out_hiz) else $error("port active after reset");
endmodule : tap_monitor
bind sram_boundary_scan_tap tap_monitor mon (.core_clk(core_clk), .rstn(rstn), .tck(tck),
  .tms_in(tms_in), .tms_drive(tms_drive), .tdo(tdo), .tdo_oe(tdo_oe),
  .mem_out_hiz(mem_out_hiz));

// File: verif/scan_tester.sv
/*
 * Behavioural scan tester: bursts of tck, mode-select and data in.
 * Assumes one caller at a time; tck rests low between calls.
 */
`timescale 1ns/1ns
module scan_tester (
  output logic tck,
  output logic tms_in,
  output logic tms_drive,
  output logic tdi_in,
  output logic tdi_drive,
  input wire logic tdo,
  input wire logic tdo_oe
);
  initial begin
    tck = 1'b0;
    {tms_in, tms_drive, tdi_in, tdi_drive} = 4'hf;
  end
  ////////////////////////
  // one tck period; line read before the rise, z when released
  task automatic step(input logic tms, input logic tdi, output logic so);
    tms_in = tms;
    tdi_in = tdi;
    #62;
    so = tdo_oe ? tdo : 1'bz;
    tck = 1'b1;
    #63;
    tck = 1'b0;
  endtask : step
  task automatic walk(input logic [5:0] pat, input int n);
    logic so;
    for (int i = 0; i < n; i++) step(pat[i], 1'b1, so);
  endtask : walk
  // pins released, levels toggle each edge, then idle
  task automatic float5();
    logic so;
    {tms_drive, tdi_drive} = 2'h0;
    repeat (5) step(~tms_in, ~tdi_in, so);
    {tms_drive, tdi_drive} = 2'h3;
    walk(6'h0, 1);
  endtask : float5
  // only defined codes loaded; idle to idle
  task automatic load_ir(input logic [2:0] code, output logic [2:0] cap);
    walk(6'h3, 4);
    for (int i = 0; i < 3; i++) step(i == 2, code[i], cap[i]);
    walk(6'h1, 2);
  endtask : load_ir
  // n-bit data scan, idle to idle
  task automatic scan_dr(input int n, input logic [95:0] din, output logic [95:0] dout);
    dout = '0;
    walk(6'h1, 3);
    for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
    walk(6'h1, 2);
  endtask : scan_dr
endmodule : scan_tester

// File: verif/tb_sram_boundary_scan_tap.sv
/*
 * Self-checking bench of the memory test port; random ring and scan data.
 * Assumes the scan tester model and the bound checker.
 */
`timescale 1ns/1ns
module tb_sram_boundary_scan_tap;
  import tap_pkg::*;
  logic core_clk, rstn, tck, tms_in, tms_drive, tdi_in, tdi_drive, tdo, tdo_oe, mem_out_hiz;
  logic [BSR_MAX-1:0] io_ring;
  logic [95:0] din, dout;
  logic [2:0] cap, op;
  logic so;
  int bad_count, n_checks, cycles;
  ////////////////////////
  sram_boundary_scan_tap uut (.core_clk(core_clk), .rstn(rstn), .tck(tck), .tms_in(tms_in),
    .tms_drive(tms_drive), .tdi_in(tdi_in), .tdi_drive(tdi_drive), .io_ring(io_ring),
    .tdo(tdo), .tdo_oe(tdo_oe), .mem_out_hiz(mem_out_hiz));
  scan_tester tester (.tck(tck), .tms_in(tms_in), .tms_drive(tms_drive), .tdi_in(tdi_in),
    .tdi_drive(tdi_drive), .tdo(tdo), .tdo_oe(tdo_oe));
  // 50 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // hang guard, run needs about 3800 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  ////////////////////////
  function automatic logic [31:0] exp_id();
    return {ID_REV_DEFAULT, ID_DEPTH_X36, ID_WIDTH_X36, ID_MAKER_DEFAULT, ID_MARKER};
  endfunction : exp_id
  function automatic logic [95:0] rnd96();
    return {$urandom, $urandom, $urandom};
  endfunction : rnd96
  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict
  ////////////////////////
  initial begin
    rstn = 1'b0;
    io_ring = '0;
    void'($urandom(48010));
    tester.step(1'b1, 1'b1, so);
    repeat (10) @(negedge core_clk);
    rstn = 1'b1;
    // identification word straight after power-up, twice
    tester.step(1'b0, 1'b1, so);
    repeat (2) begin
      tester.scan_dr(32, rnd96(), dout);
      check(dout[31:0], exp_id());
    end
    $display("test id done");
    // ring capture under the three ring instructions
    tester.walk(6'h1f, 6);
    for (int k = 0; k < 3; k++) begin
      op = (k == 0) ? OP_EXTEST : (k == 1) ? OP_SAMPLE_Z : OP_SAMPLE;
      din = rnd96();
      @(negedge core_clk);
      io_ring = din[BSR_MAX-1:0];
      tester.load_ir(op, cap);
      check(cap, 3'h1);
      repeat (8) @(negedge core_clk);
      check(mem_out_hiz, op != OP_SAMPLE);
      repeat (2) begin
        din = rnd96();
        tester.scan_dr(BSR_LEN_X36 + 1, din, dout);
        check(dout[70:0], {din[0], io_ring});
      end
    end
    $display("test ring done");
    // single bypass bit, captured as zero
    tester.load_ir(OP_BYPASS, cap);
    din = rnd96();
    tester.scan_dr(8, din, dout);
    check(dout[7:0], {din[6:0], 1'b0});
    $display("test bypass done");
    // released pins drift to reset from a floating instruction
    tester.load_ir(OP_EXTEST, cap);
    tester.float5();
    repeat (8) @(negedge core_clk);
    check(mem_out_hiz, 1'b0);
    tester.scan_dr(1, rnd96(), dout);
    check(dout[0], 1'b1);
    $display("test float done");
    print_verdict();
  end
endmodule : tb_sram_boundary_scan_tap
